// *** rtca_pkg.sv ***
`default_nettype none
// ****************************************************************
// calendar and alarm register constants
// ****************************************************************
package rtca_pkg;

  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // register byte offsets
  localparam logic [7:0]  OFF_CLK_CTRL  = 8'h00; // clock control register
  localparam logic [7:0]  OFF_ALM_CTRL  = 8'h04; // alarm control register
  localparam logic [7:0]  OFF_DATE      = 8'h10; // calendar date value
  localparam logic [7:0]  OFF_ATIME     = 8'h20; // alarm time value
  localparam logic [7:0]  OFF_ADATE     = 8'h30; // alarm date value

  // clock control register fields
  localparam int          CLK_WREN_BIT  = 3;     // clock write enable

  // alarm control register fields
  localparam int          ALM_EN_BIT    = 15;    // alarm enable
  localparam int          ALM_MODE_BIT  = 14;    // mode_a, counter wraps
  localparam int          ALM_SEL_LSB   = 8;     // field compare select
  localparam int          ALM_SEL_W     = 6;
  localparam int          ALM_RPT_LSB   = 0;     // alarm repeat count
  localparam int          ALM_RPT_W     = 8;

  // compare select bit order: sec, min, hour, weekday, day, month
  localparam int          NUM_FIELDS    = 6;

  // implemented bits per register, per nibble
  localparam logic [31:0] DATE_IMPL     = 32'hffff_ff0f;
  localparam logic [31:0] ATIME_IMPL    = 32'hffff_ff00;
  localparam logic [31:0] ADATE_IMPL    = 32'h00ff_ff0f;

  // largest legal bcd digit per nibble
  localparam logic [31:0] DATE_MAX      = 32'h9919_3906;
  localparam logic [31:0] ATIME_MAX     = 32'h2959_5900;
  localparam logic [31:0] ADATE_MAX     = 32'h0019_3906;

  // reset values, fields are undefined at power-on so zero is chosen; RPT_MAX is the mode_a wrap value
  localparam logic [31:0] DATE_RST      = 32'h0000_0000;
  localparam logic [31:0] ATIME_RST     = 32'h0000_0000;
  localparam logic [31:0] ADATE_RST     = 32'h0000_0000;
  localparam logic [7:0]  RPT_RST       = 8'h00;
  localparam logic [7:0]  RPT_MAX       = 8'hff;
  localparam logic [5:0]  SEL_RST       = 6'h00;

endpackage : rtca_pkg
`default_nettype wire

// *** rtca_alarm_match.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// alarm field comparator
// ****************************************************************
module rtca_alarm_match
(
  // current time and date, packed bcd
  input  wire logic [31:0] cur_time,
  input  wire logic [31:0] cur_date,
  // alarm value registers
  input  wire logic [31:0] alm_time,
  input  wire logic [31:0] alm_date,
  // which fields take part
  input  wire logic [5:0]  field_sel,
  // all selected fields equal
  output logic             match
);

  logic [63:0] cur_all; // date above time, byte per field
  logic [63:0] alm_all;
  logic [5:0]  field_eq; // per field equality

  assign cur_all = {cur_date, cur_time};
  assign alm_all = {alm_date, alm_time};

  // ****************************************************************
  // one byte compare per field, byte 1 upward
  // ****************************************************************
  // weekday byte upper nibble reads zero in both words, so a full
  // byte compare is safe and keeps the loop uniform
  genvar g;
  generate
    for (g = 0; g < rtca_pkg::NUM_FIELDS; g++)
    begin : g_field
      assign field_eq[g] = (cur_all[8*(g+1) +: 8] == alm_all[8*(g+1) +: 8]);
    end
  endgenerate

  // unselected fields always agree; no selection means every tick
  assign match = &(~field_sel | field_eq);

endmodule : rtca_alarm_match
`default_nettype wire

// *** rtca_calendar_alarm_regs.sv ***
// Operation
// - year held as two bcd digits, top
// - month tens digit holds zero or one
// - month ones digit holds zero to nine
// - day tens digit holds zero to three
// - day ones digit holds zero to nine
// - weekday digit in low nibble, 0-6
// - date bits seven to four read zero
// - date writes only while write enable set
// - alarm hour digits in top byte
// - alarm minute digits, tens 0-5, ones 0-9
// - alarm second digits, tens 0-5, ones 0-9
// - alarm time low byte reads zero
// - alarm date top byte, bits 7-4 zero
// - alarm month digits, tens 0-1, ones 0-9
// - alarm day digits, tens 0-3, ones 0-9
// - alarm weekday digit in low nibble, 0-6
// - alarm event decrements repeat, wraps in mode_a
// - event at zero count without mode_a disables
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module rtca_calendar_alarm_regs
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // from the time-keeping counters
  input  wire logic [31:0] cur_time,
  input  wire logic        second_tick,
  // to the rest of the clock unit
  output logic [31:0]      calendar_date_value,
  output logic             clock_write_enable,
  output logic             alarm_enable,
  output logic             alarm_event
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] alarm_time_value;    // alarm hh:mm:ss
  logic [31:0] alarm_date_value;    // alarm month, day, weekday
  logic        mode_a;              // repeat counter wraps
  logic [5:0]  field_sel;           // fields compared
  logic [7:0]  alarm_repeat_count;  // events left
  logic [31:0] next_prdata;         // read mux
  logic        hit_clk;             // address decodes
  logic        hit_alm;
  logic        hit_date;
  logic        hit_atime;
  logic        hit_adate;
  logic        mapped;
  logic        wr_access;           // write takes effect this edge
  logic        wr_date;
  logic        wr_atime;
  logic        wr_adate;
  logic        wr_alm_ctl;
  logic        match;               // selected fields equal
  logic        fire;                // alarm event this edge

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // zero wait states: every access finishes in its first access cycle
  assign pready    = 1'b1;
  assign hit_clk   = (paddr == rtca_pkg::OFF_CLK_CTRL);
  assign hit_alm   = (paddr == rtca_pkg::OFF_ALM_CTRL);
  assign hit_date  = (paddr == rtca_pkg::OFF_DATE);
  assign hit_atime = (paddr == rtca_pkg::OFF_ATIME);
  assign hit_adate = (paddr == rtca_pkg::OFF_ADATE);
  assign mapped    = hit_clk | hit_alm | hit_date | hit_atime | hit_adate;
  // unmapped address answers with an error in the access phase
  assign pslverr   = psel & penable & ~mapped;
  assign wr_access = psel & penable & pwrite & pready;

  // the date only opens while the write enable is set
  assign wr_date    = wr_access & hit_date & clock_write_enable;
  assign wr_atime   = wr_access & hit_atime;
  assign wr_adate   = wr_access & hit_adate;
  assign wr_alm_ctl = wr_access & hit_alm;

  // ****************************************************************
  // read mux
  // ****************************************************************
  // unimplemented bits are never written, so they read as zero
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_clk)
    begin
      next_prdata[rtca_pkg::CLK_WREN_BIT] = clock_write_enable;
    end
    else if (hit_alm)
    begin
      next_prdata[rtca_pkg::ALM_EN_BIT]   = alarm_enable;
      next_prdata[rtca_pkg::ALM_MODE_BIT] = mode_a;
      next_prdata[rtca_pkg::ALM_SEL_LSB +: rtca_pkg::ALM_SEL_W] = field_sel;
      next_prdata[rtca_pkg::ALM_RPT_LSB +: rtca_pkg::ALM_RPT_W] = alarm_repeat_count;
    end
    else if (hit_date)
    begin
      next_prdata = calendar_date_value;
    end
    else if (hit_atime)
    begin
      next_prdata = alarm_time_value;
    end
    else if (hit_adate)
    begin
      next_prdata = alarm_date_value;
    end
  end

  // read data captured in the setup cycle, stable through access
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // clock control register
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      clock_write_enable <= 1'b0;
    end
    else if (wr_access && hit_clk)
    begin
      clock_write_enable <= pwdata[rtca_pkg::CLK_WREN_BIT];
    end
  end

  // ****************************************************************
  // value registers, one process per nibble
  // ****************************************************************
  // a digit outside its bcd range is refused and the old digit kept,
  // so the fields can never hold an illegal value; the trade is that
  // software sees no error, only an unchanged digit on read back
  genvar n;
  generate
    for (n = 0; n < 8; n++)
    begin : g_nib
      logic [3:0] wnib; // write data for this nibble
      assign wnib = pwdata[4*n +: 4];

      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
        begin
          calendar_date_value[4*n +: 4] <= rtca_pkg::DATE_RST[4*n +: 4];
          alarm_time_value[4*n +: 4]    <= rtca_pkg::ATIME_RST[4*n +: 4];
          alarm_date_value[4*n +: 4]    <= rtca_pkg::ADATE_RST[4*n +: 4];
        end
        else
        begin
          // date digits and weekday, gated write
          if (wr_date && rtca_pkg::DATE_IMPL[4*n]
              && (wnib <= rtca_pkg::DATE_MAX[4*n +: 4]))
          begin
            calendar_date_value[4*n +: 4] <= wnib;
          end
          // alarm hour, minute and second digits
          if (wr_atime && rtca_pkg::ATIME_IMPL[4*n]
              && (wnib <= rtca_pkg::ATIME_MAX[4*n +: 4]))
          begin
            alarm_time_value[4*n +: 4] <= wnib;
          end
          // alarm month, day and weekday digits
          if (wr_adate && rtca_pkg::ADATE_IMPL[4*n]
              && (wnib <= rtca_pkg::ADATE_MAX[4*n +: 4]))
          begin
            alarm_date_value[4*n +: 4] <= wnib;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // alarm compare
  // ****************************************************************
  rtca_alarm_match u_match
  (
    .cur_time  (cur_time),
    .cur_date  (calendar_date_value),
    .alm_time  (alarm_time_value),
    .alm_date  (alarm_date_value),
    .field_sel (field_sel),
    .match     (match)
  );

  // compare once per second so a match lasting a second fires once
  assign fire = second_tick & alarm_enable & match;

  // registered event pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      alarm_event <= 1'b0;
    end
    else
    begin
      alarm_event <= fire;
    end
  end

  // ****************************************************************
  // alarm control and repeat counter
  // ****************************************************************
  // a software write in the same cycle as an event wins; software
  // is rewriting the whole alarm setup and that should stand
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      alarm_enable       <= 1'b0;
      mode_a             <= 1'b0;
      field_sel          <= rtca_pkg::SEL_RST;
      alarm_repeat_count <= rtca_pkg::RPT_RST;
    end
    else if (wr_alm_ctl)
    begin
      alarm_enable       <= pwdata[rtca_pkg::ALM_EN_BIT];
      mode_a             <= pwdata[rtca_pkg::ALM_MODE_BIT];
      field_sel          <= pwdata[rtca_pkg::ALM_SEL_LSB +: rtca_pkg::ALM_SEL_W];
      alarm_repeat_count <= pwdata[rtca_pkg::ALM_RPT_LSB +: rtca_pkg::ALM_RPT_W];
    end
    else if (fire)
    begin
      if (alarm_repeat_count != rtca_pkg::RPT_RST)
      begin
        // ordinary countdown
        alarm_repeat_count <= alarm_repeat_count - 8'h01;
      end
      else if (mode_a)
      begin
        // mode_a style: roll over and keep going
        alarm_repeat_count <= rtca_pkg::RPT_MAX;
      end
      else
      begin
        // last event: switch the alarm off
        alarm_enable <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  date_gate_a : assert property (wr_access && hit_date && !clock_write_enable
    |=> $stable(calendar_date_value))
    else $error("date changed while write enable clear");

  date_load_a : assert property (wr_date && (pwdata & rtca_pkg::DATE_IMPL) == pwdata
    && pwdata[31:28] <= 4'h9 && pwdata[27:24] <= 4'h9 && pwdata[23:20] <= 4'h1
    && pwdata[19:16] <= 4'h9 && pwdata[15:12] <= 4'h3 && pwdata[11:8] <= 4'h9
    && pwdata[3:0] <= 4'h6 |=> calendar_date_value == $past(pwdata))
    else $error("legal date write not stored");

  date_zero_a : assert property (calendar_date_value[7:4] == 4'h0)
    else $error("date bits 7-4 not zero");

  date_range_a : assert property (calendar_date_value[23:20] <= 4'h1
    && calendar_date_value[19:16] <= 4'h9 && calendar_date_value[15:12] <= 4'h3
    && calendar_date_value[11:8] <= 4'h9 && calendar_date_value[3:0] <= 4'h6
    && calendar_date_value[31:28] <= 4'h9)
    else $error("date digit out of range");

  atime_range_a : assert property (alarm_time_value[31:28] <= 4'h2
    && alarm_time_value[27:24] <= 4'h9 && alarm_time_value[23:20] <= 4'h5
    && alarm_time_value[19:16] <= 4'h9 && alarm_time_value[15:12] <= 4'h5
    && alarm_time_value[11:8] <= 4'h9 && alarm_time_value[7:0] == 8'h00)
    else $error("alarm time digit out of range");

  adate_range_a : assert property (alarm_date_value[31:24] == 8'h00
    && alarm_date_value[7:4] == 4'h0 && alarm_date_value[23:20] <= 4'h1
    && alarm_date_value[19:16] <= 4'h9 && alarm_date_value[15:12] <= 4'h3
    && alarm_date_value[11:8] <= 4'h9 && alarm_date_value[3:0] <= 4'h6)
    else $error("alarm date field out of range");

  rpt_down_a : assert property (fire && !wr_alm_ctl && alarm_repeat_count != 8'h00
    |=> alarm_repeat_count == $past(alarm_repeat_count) - 8'h01 && alarm_enable)
    else $error("repeat count not decremented");

  rpt_wrap_a : assert property (fire && !wr_alm_ctl && alarm_repeat_count == 8'h00
    && mode_a |=> alarm_repeat_count == 8'hff && alarm_enable)
    else $error("repeat count did not wrap");

  auto_off_a : assert property (fire && !wr_alm_ctl && alarm_repeat_count == 8'h00
    && !mode_a |=> !alarm_enable && alarm_repeat_count == 8'h00)
    else $error("alarm not disabled at last event");

  alarm_fire_a : assert property (second_tick && alarm_enable && match
    |=> alarm_event ##1 !alarm_event || $past(fire, 1))
    else $error("alarm event missing");

  no_spur_a : assert property (!second_tick || !alarm_enable |=> !alarm_event)
    else $error("alarm event without enabled tick");

  ctl_write_a : assert property (wr_access && hit_clk
    |=> clock_write_enable == $past(pwdata[rtca_pkg::CLK_WREN_BIT]))
    else $error("write enable not stored");

  date_read_a : assert property (psel && penable && !pwrite && hit_date
    |-> prdata[7:4] == 4'h0)
    else $error("date read bits 7-4 not zero");

  atime_read_a : assert property (psel && penable && !pwrite && hit_atime
    |-> prdata[7:0] == 8'h00)
    else $error("alarm time read low byte not zero");

  adate_read_a : assert property (psel && penable && !pwrite && hit_adate
    |-> prdata[31:24] == 8'h00 && prdata[7:4] == 4'h0)
    else $error("alarm date read spare bits not zero");

  date_write_c : cover property (wr_date ##1 calendar_date_value != $past(calendar_date_value));
  alarm_wrap_c : cover property (fire && mode_a && alarm_repeat_count == 8'h00);
  alarm_off_c  : cover property (fire && !mode_a && alarm_repeat_count == 8'h00 ##1 !alarm_enable);
  apb_err_c    : cover property (pslverr);

endmodule : rtca_calendar_alarm_regs
`default_nettype wire

// *** rtca_calendar_alarm_regs_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rtca_calendar_alarm_regs_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic        clk         = 1'b0;         // 25 MHz
  logic        reset       = 1'b1;         // async, high
  logic        psel        = 1'b0;         // apb select
  logic        penable     = 1'b0;         // apb access
  logic        pwrite      = 1'b0;         // apb direction
  logic [7:0]  paddr       = 8'h00;        // byte address
  logic [31:0] pwdata      = 32'h0000_0000;
  logic [31:0] cur_time    = 32'h0000_0000; // counters stand-in
  logic        second_tick = 1'b0;         // once-per-second pulse
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] calendar_date_value;
  logic        clock_write_enable;
  logic        alarm_enable;
  logic        alarm_event;
  int          mismatches  = 0;            // failed compares
  int          checks_done = 0;            // all compares
  int          cycles      = 0;            // timeout counter
  int          events_seen = 0;            // alarm pulses seen
  int          events_exp  = 0;            // alarm pulses due
  logic [31:0] seed        = 32'h0001_0d67; // 68967
  logic [32:0] exp_q[$];                   // {pslverr, prdata} notes
  logic [7:0]  offs[3];                    // date, alarm time, alarm date
  logic [31:0] impl[3];                    // implemented bits
  logic [31:0] mx[3];                      // largest digits
  logic [31:0] mdl[3];                     // expected contents

  always #20 clk = ~clk;

  rtca_calendar_alarm_regs dut_u
  (
    .clk                 (clk),
    .reset               (reset),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .cur_time            (cur_time),
    .second_tick         (second_tick),
    .calendar_date_value (calendar_date_value),
    .clock_write_enable  (clock_write_enable),
    .alarm_enable        (alarm_enable),
    .alarm_event         (alarm_event)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // four-state compare, counted
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // per nibble: legal digit taken, else old digit kept
  function automatic logic [31:0] fit(input logic [31:0] old, input logic [31:0] nw,
                                      input logic [31:0] im, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 8; i++)
      if (im[4*i+:4] != 4'h0 && nw[4*i+:4] <= m[4*i+:4])
        r[4*i+:4] = nw[4*i+:4];
    return r;
  endfunction : fit

  // one apb transfer; idle cycle first so no signal is set twice per step
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // hold until pready sampled high; only the hang guard ends a stall
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read with the expected answer noted first
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // one second tick, then count pulses
  task tick(input int fire);
    @(posedge clk);
    second_tick <= 1'b1;
    @(posedge clk);
    second_tick <= 1'b0;
    repeat (3) @(posedge clk);
    events_exp += fire;
    check("alarm events", 33'(events_seen), 33'(events_exp));
  endtask : tick

  // counts, verdict, end of run
  task close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ****************************************************************
  // watchers
  // ****************************************************************
  // read answers taken at the completing edge
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        check("unexpected read", 33'h0, 33'h1);
      else
        check("read word", {pslverr, prdata}, exp_q.pop_front());
    end
    if (alarm_event === 1'b1)
      events_seen++;
  end

  // hang guard, far beyond the roughly 720 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      close_out();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    offs = '{rtca_pkg::OFF_DATE, rtca_pkg::OFF_ATIME, rtca_pkg::OFF_ADATE};
    impl = '{rtca_pkg::DATE_IMPL, rtca_pkg::ATIME_IMPL, rtca_pkg::ADATE_IMPL};
    mx   = '{rtca_pkg::DATE_MAX, rtca_pkg::ATIME_MAX, rtca_pkg::ADATE_MAX};
    mdl  = '{32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // reset values, zero chosen
    for (int k = 0; k < 3; k++)
      rd(offs[k], 33'h0);
    rd(rtca_pkg::OFF_CLK_CTRL, 33'h0);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'h0);
    $display("test reset values done");
    // locked date refuses writes
    apb(1'b1, rtca_pkg::OFF_DATE, 32'h2412_3106);
    rd(rtca_pkg::OFF_DATE, 33'h0);
    apb(1'b1, rtca_pkg::OFF_CLK_CTRL, 32'h0000_0008);
    rd(rtca_pkg::OFF_CLK_CTRL, 33'h8);
    check("write enable", {32'h0, clock_write_enable}, 33'h1);
    $display("test write lock done");
    // boundary digits, then random words per nibble
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, offs[k], 32'hffff_ffff);
      rd(offs[k], 33'h0);
      apb(1'b1, offs[k], mx[k]);
      mdl[k] = mx[k];
      rd(offs[k], {1'b0, mdl[k]});
    end
    repeat (30)
      for (int k = 0; k < 3; k++)
      begin
        mdl[k] = fit(mdl[k], seed, impl[k], mx[k]);
        apb(1'b1, offs[k], seed);
        void'(xs());
        rd(offs[k], {1'b0, mdl[k]});
      end
    check("date output", {1'b0, calendar_date_value}, {1'b0, mdl[0]});
    $display("test digit fields done");
    // relock, then write must not land
    apb(1'b1, rtca_pkg::OFF_CLK_CTRL, 32'h0000_0000);
    apb(1'b1, rtca_pkg::OFF_DATE, 32'h1111_1101);
    rd(rtca_pkg::OFF_DATE, {1'b0, mdl[0]});
    // unmapped place: error, zero, no side effect
    apb(1'b1, 8'h14, 32'h1111_1111);
    rd(8'h14, {1'b1, 32'h0});
    rd(rtca_pkg::OFF_DATE, {1'b0, mdl[0]});
    $display("test lock and unmapped done");
    // alarm setup: 12:34:56, date 11/25 weekday 3
    apb(1'b1, rtca_pkg::OFF_CLK_CTRL, 32'h0000_0008);
    apb(1'b1, rtca_pkg::OFF_DATE, 32'h2411_2503);
    apb(1'b1, rtca_pkg::OFF_ATIME, 32'h1234_5600);
    apb(1'b1, rtca_pkg::OFF_ADATE, 32'h0011_2503);
    cur_time <= 32'h1234_5600;
    // time fields selected, count two, no wrap
    apb(1'b1, rtca_pkg::OFF_ALM_CTRL, 32'h0000_8702);
    tick(1);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'h8701);
    tick(1);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'h8700);
    tick(1);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'h0700);
    check("alarm enable", {32'h0, alarm_enable}, 33'h0);
    tick(0);
    // wrap mode keeps the alarm armed
    apb(1'b1, rtca_pkg::OFF_ALM_CTRL, 32'h0000_c700);
    tick(1);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'hc7ff);
    // seconds differ: no event
    cur_time <= 32'h1234_5700;
    tick(0);
    // date fields only: time mismatch ignored
    apb(1'b1, rtca_pkg::OFF_ALM_CTRL, 32'h0000_f805);
    tick(1);
    rd(rtca_pkg::OFF_ALM_CTRL, 33'hf804);
    apb(1'b1, rtca_pkg::OFF_ADATE, 32'h0011_2504);
    tick(0);
    $display("test alarm done");
    repeat (2) @(posedge clk);
    check("notes left", 33'(exp_q.size()), 33'h0);
    close_out();
  end
endmodule : rtca_calendar_alarm_regs_tb
`default_nettype wire
